// [i2c_flag_pkg.sv]
// Constants and carriers for the I2C status-flag block.
// Assumes one 40 MHz clock and an AXI4-Lite master on the register side.
`default_nettype none
package i2c_flag_pkg;
  // Register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] DATA_OFS = 5'h10;
  localparam logic [4:0] STATUS_ONE_REGISTER_OFS = 5'h14;
  localparam logic [4:0] STATUS_TWO_REGISTER_OFS = 5'h18;
  // Status one bit positions
  localparam int B_START = 0;
  localparam int B_ADDR  = 1;
  localparam int B_BYTE  = 2;
  localparam int B_HDR   = 3;
  localparam int B_STOP  = 4;
  localparam int B_RXF   = 6;
  localparam int B_TXE   = 7;
  localparam int B_MISP  = 8;
  localparam int B_ARB   = 9;
  localparam int B_OVR   = 11;
  // Implemented bits; reserved read as zero
  localparam logic [15:0] STATUS_ONE_REGISTER_MASK = 16'h0BDF;
  // Control one bits
  localparam int C_EN    = 0;
  localparam int C_NOSTR = 1;
  localparam int C_PEC   = 2;
  // Status two bits
  localparam int S2_ROLE = 0;
  localparam int S2_BUSY = 1;
  localparam int S2_DIR  = 2;
  // Bus answers and bus timing
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] SLOT_BITS   = 4'h9;
  localparam logic [3:0] FIRST_BIT   = 4'h1;

  // Events and levels from the byte engine, same clock
  typedef struct packed {
    logic       start_sent;    // Pulse: start put on bus
    logic       hdr_sent;      // Pulse: 10-bit header byte sent
    logic       addr_done;     // Pulse: address acked, controller
    logic       addr_match;    // Pulse: enabled address matched, target
    logic       byte_rx;       // Pulse: data byte with ACK received
    logic       byte_req;      // Pulse: shifter needs next byte
    logic       nack;          // Pulse: NACK seen
    logic       arb_lost;      // Pulse: arbitration lost
    logic       addr_stage;    // Level: address phase running
    logic       addr_ack_slot; // Level: address ACK slot
    logic       tx_dir;        // Level: transmit direction
    logic       pec_next;      // Level: next byte is PEC
    logic       smbus;         // Level: SMBus mode
    logic [7:0] rx_byte;       // Received byte
  } core_ev_s;

  // Whole state of the flag block
  typedef struct packed {
    logic [1:0]  sync1;   // Pin stage one {scl,sda}
    logic [1:0]  sync2;   // Pin stage two
    logic [1:0]  prev;    // Previous stage-two value
    logic [3:0]  bitcnt;  // SCL rises in current slot
    logic        busy;    // Bus between start and stop
    logic [15:0] flags;   // Status one
    logic        role;    // Controller role
    logic [2:0]  ctrl;    // Control one
    logic        armed;   // Status one was read last
    logic        first;   // Shifter waits for first byte
    logic        txfull;  // Transmit buffer holds a byte
    logic [7:0]  txbuf;   // Transmit buffer
    logic [7:0]  txout;   // Byte handed to shifter
    logic        txload;  // Hand-over pulse
    logic [7:0]  rxbuf;   // Receive buffer
    logic [7:0]  rxhold;  // Byte parked while stretching
    logic        holdv;   // Parked byte valid
    logic        lastack; // Last byte was acked
    logic        awgot;   // Write address taken
    logic        wgot;    // Write data taken
    logic [4:0]  waddr;   // Held write address
    logic [31:0] wdata;   // Held write data
    logic [3:0]  wstrb;   // Held write strobes
    logic        bvalid;  // Write answer pending
    logic [1:0]  bresp;   // Write answer code
    logic        rvalid;  // Read answer pending
    logic [31:0] rdata;   // Read data
    logic [1:0]  rresp;   // Read answer code
  } flag_state_s;
endpackage : i2c_flag_pkg
`default_nettype wire

// [i2c_status_flags.sv]
// Status-one flag logic of an I2C/SMBus controller with AXI4-Lite access.
// Assumes the byte engine runs on aclk and pulses its events for one cycle;
// SCL and SDA pins are asynchronous and are synchronised here.
`default_nettype none
// Operation
// [R1] Arbitration loss sets flag, drops controller role
// [R2] Arbitration, bus-error flags: write zero or disable
// [R3] SMBus target: no loss at address ACK
// [R4] Misplaced start/stop sets bus-error flag
// [R5] Transmit-empty set when buffer empty, not address
// [R6] Transmit-empty clears: data write, start/stop, disable
// [R7] No transmit-empty after NACK or PEC next
// [R8] First write or write under byte-done keeps empty
// [R9] Receive-full set on data byte, not address
// [R10] Receive-full clears on access; stays under byte-done
// [R11] Target stop after ACK sets stop flag
// [R12] Stop, header flags clear: status read, control write
// [R13] Header-sent set after first 10-bit byte
// [R14] Byte-done set when stretching and buffer stalled
// [R15] No byte-done after NACK or PEC next
// [R16] Byte-done clears: read then data access, start/stop
// [R17] Controller address-phase flag on address ACK
// [R18] Target address-phase flag on address match
// [R19] Address flag clears: status one then two read
// [R20] Start-sent flag set; clears read then write
// [R21] Controller role clears on stop or disable
// [R22] No stretching: overrun drops, underrun resends
// [R23] Flags reset zero, reserved bits read zero
module i2c_status_flags
  import i2c_flag_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire core_ev_s    ev,
  output logic [7:0]       tx_byte,
  output logic             tx_load,
  output logic             periph_enable,
  output logic             stretch_disable,
  output logic             pec_request,
  output logic             controller_role_flag
);

  flag_state_s q;        // Registered state
  flag_state_s d;        // Next state
  logic        start_c;  // Start seen on bus
  logic        stop_c;   // Stop seen on bus
  logic        illegal;  // Condition inside a byte slot
  logic        en;       // Peripheral enabled
  logic        do_wr;    // Register write this cycle
  logic        do_rd;    // Register read this cycle
  logic        rx_take;  // Data byte accepted this cycle

  // Register address compare
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a[4:2] == o[4:2]);
  endfunction : hit

  // Handshake readies straight from state
  assign s_axi_awready = !q.awgot && !q.bvalid;
  assign s_axi_wready  = !q.wgot && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign tx_byte              = q.txout;
  assign tx_load              = q.txload;
  assign periph_enable        = q.ctrl[C_EN];
  assign stretch_disable      = q.ctrl[C_NOSTR];
  assign pec_request          = q.ctrl[C_PEC];
  assign controller_role_flag = q.role;

  // Bus conditions from second sync stage only
  assign start_c = q.sync2[1] && q.prev[1] && q.prev[0] && !q.sync2[0];
  assign stop_c  = q.sync2[1] && q.prev[1] && !q.prev[0] && q.sync2[0];
  // Legal only before the second SCL rise of a slot
  assign illegal = q.busy && (q.bitcnt > FIRST_BIT);
  assign en      = q.ctrl[C_EN];
  assign do_wr   = q.awgot && q.wgot && !q.bvalid;
  assign do_rd   = s_axi_arvalid && s_axi_arready;
  assign rx_take = ev.byte_rx && !ev.arb_lost && !ev.addr_stage && !ev.nack;

  // Next-state logic: software clears first, hardware sets win after, disable clears last of all
  always_comb begin
    d = q;
    d.txload = 1'b0;
    // Pin synchronisers; stage one feeds only stage two
    d.sync1 = {scl_in, sda_in};
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    // Slot bit counter on SCL rising edges
    if (start_c || stop_c) begin
      d.bitcnt = '0;
    end else if (q.sync2[1] && !q.prev[1]) begin
      d.bitcnt = (q.bitcnt == SLOT_BITS) ? FIRST_BIT : q.bitcnt + FIRST_BIT;
    end
    if (start_c) begin
      d.busy = 1'b1;
    end else if (stop_c) begin
      d.busy = 1'b0;
    end

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.awgot = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wgot  = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Register writes
    if (do_wr) begin
      d.awgot  = 1'b0;
      d.wgot   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      d.armed  = 1'b0;
      if (hit(q.waddr, CTRL_OFS)) begin
        if (q.wstrb[0]) begin
          d.ctrl = q.wdata[2:0];
        end
        // [R12] Read-then-write clear
        if (q.armed) begin
          d.flags[B_STOP] = 1'b0;
          d.flags[B_HDR]  = 1'b0;
        end
      end else if (hit(q.waddr, DATA_OFS)) begin
        // [R20] [R16] Read-then-write clear
        if (q.armed) begin
          d.flags[B_START] = 1'b0;
          d.flags[B_BYTE]  = 1'b0;
        end
        if (q.wstrb[0]) begin
          // [R10] Data write empties receive side unless a byte is parked
          if (!q.holdv) begin
            d.flags[B_RXF] = 1'b0;
          end
          d.txbuf = q.wdata[7:0];
          // [R8] Shifter waiting: byte goes straight through
          if (q.first || q.flags[B_BYTE]) begin
            d.txout  = q.wdata[7:0];
            d.txload = 1'b1;
            d.first  = 1'b0;
          end else begin
            // [R6] Buffer now holds a byte
            d.txfull       = 1'b1;
            d.flags[B_TXE] = 1'b0;
          end
        end
      end else if (hit(q.waddr, STATUS_ONE_REGISTER_OFS)) begin
        // [R2] Write-zero clear of error flags
        if (q.wstrb[1]) begin
          d.flags[B_MISP] = q.flags[B_MISP] & q.wdata[B_MISP];
          d.flags[B_ARB]  = q.flags[B_ARB] & q.wdata[B_ARB];
          d.flags[B_OVR]  = q.flags[B_OVR] & q.wdata[B_OVR];
        end
      end else if (!hit(q.waddr, STATUS_TWO_REGISTER_OFS)) begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Register reads
    if (do_rd) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      d.armed  = 1'b0;
      if (hit(s_axi_araddr, CTRL_OFS)) begin
        d.rdata[2:0] = q.ctrl;
      end else if (hit(s_axi_araddr, DATA_OFS)) begin
        d.rdata[7:0] = q.rxbuf;
        // [R16] Read-then-read clear
        if (q.armed) begin
          d.flags[B_BYTE] = 1'b0;
        end
        // [R10] Parked byte refills, flag stays
        if (q.holdv) begin
          d.rxbuf = q.rxhold;
          d.holdv = 1'b0;
        end else begin
          d.flags[B_RXF] = 1'b0;
        end
      end else if (hit(s_axi_araddr, STATUS_ONE_REGISTER_OFS)) begin
        // [R23] Reserved bits masked
        d.rdata[15:0] = q.flags & STATUS_ONE_REGISTER_MASK;
        d.armed       = 1'b1;
      end else if (hit(s_axi_araddr, STATUS_TWO_REGISTER_OFS)) begin
        d.rdata[S2_ROLE] = q.role;
        d.rdata[S2_BUSY] = q.busy;
        d.rdata[S2_DIR]  = ev.tx_dir && en;
        // [R19] Read-then-read clear
        if (q.armed) begin
          d.flags[B_ADDR] = 1'b0;
        end
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end

    // Bus conditions
    if (start_c || stop_c) begin
      // [R6] Start or stop empties transmit flag
      d.flags[B_TXE] = 1'b0;
      d.first        = 1'b0;
      // [R16] Start or stop in transmit clears byte-done
      if (ev.tx_dir) begin
        d.flags[B_BYTE] = 1'b0;
      end
      // [R4] Misplaced condition
      if (illegal) begin
        d.flags[B_MISP] = 1'b1;
      end
    end
    if (stop_c) begin
      // [R11] Target stop after an acked byte
      if (!q.role && q.lastack && q.busy) begin
        d.flags[B_STOP] = 1'b1;
      end
      // [R21] Stop ends controller role
      d.role = 1'b0;
    end

    // [R20] Start sent by controller
    if (ev.start_sent) begin
      d.flags[B_START] = 1'b1;
      d.role           = 1'b1;
      // [R6] [R16] Own start empties transmit side
      d.flags[B_TXE]   = 1'b0;
      d.first          = 1'b0;
      if (ev.tx_dir) begin
        d.flags[B_BYTE] = 1'b0;
      end
    end
    // [R13] Header acked in 10-bit mode
    if (ev.hdr_sent && !ev.nack) begin
      d.flags[B_HDR] = 1'b1;
    end
    // [R17] [R18] Address phase done or matched
    if (!ev.nack && ((ev.addr_done && q.role) || (ev.addr_match && !q.role))) begin
      d.flags[B_ADDR] = 1'b1;
      d.lastack       = 1'b1;
      if (ev.tx_dir) begin
        d.flags[B_TXE] = 1'b1;
        d.first        = 1'b1;
      end
    end
    if (ev.nack) begin
      d.lastack = 1'b0;
    end

    // Received data byte
    if (rx_take) begin
      d.lastack = 1'b1;
      if (!d.flags[B_RXF]) begin
        // [R9] Byte lands in empty buffer
        d.rxbuf        = ev.rx_byte;
        d.flags[B_RXF] = 1'b1;
      end else if (!q.ctrl[C_NOSTR]) begin
        // [R14] Stretch and park byte
        d.rxhold        = ev.rx_byte;
        d.holdv         = 1'b1;
        d.flags[B_BYTE] = 1'b1;
      end else if (!q.role) begin
        // [R22] Overrun: byte dropped
        d.flags[B_OVR] = 1'b1;
      end
    end

    // Shifter asks for the next byte
    if (ev.byte_req && ev.tx_dir && !ev.nack && !ev.addr_stage) begin
      if (d.txfull) begin
        d.txout  = d.txbuf;
        d.txload = 1'b1;
        d.txfull = 1'b0;
        // [R5] [R7] Empty again unless PEC follows
        if (!ev.pec_next) begin
          d.flags[B_TXE] = 1'b1;
        end
      end else if (!q.ctrl[C_NOSTR]) begin
        // [R5] [R14] [R15] Empty first; stall only if already empty
        if (!ev.pec_next) begin
          d.flags[B_TXE] = 1'b1;
          if (q.flags[B_TXE]) begin
            d.flags[B_BYTE] = 1'b1;
          end
        end
      end else if (!q.role) begin
        // [R22] Underrun: previous byte resent
        d.txload       = 1'b1;
        d.flags[B_OVR] = 1'b1;
      end
    end

    // [R1] [R3] Arbitration loss, not at SMBus target address ACK
    if (ev.arb_lost && !(ev.smbus && !q.role && ev.addr_ack_slot)) begin
      d.flags[B_ARB] = 1'b1;
      d.role         = 1'b0;
    end

    // [R2] [R21] Disabled peripheral holds all flags clear
    if (!en) begin
      d.flags  = '0;
      d.role   = 1'b0;
      d.first  = 1'b0;
      d.txfull = 1'b0;
      d.holdv  = 1'b0;
      d.armed  = 1'b0;
    end
  end

  // State register; reset gives all-zero flags
  always_ff @(posedge aclk) begin
    // [R23] Zero after reset
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  arb_role_drop_a: assert property ( // [R1]
    ev.arb_lost && !ev.smbus && en |=> q.flags[B_ARB] && !q.role)
    else $error("arbitration loss kept controller role");
  disable_clear_a: assert property ( // [R2]
    !en |=> q.flags == 16'h0000 && !q.role)
    else $error("flags survive disable");
  smbus_addr_ack_a: assert property ( // [R3]
    ev.arb_lost && ev.smbus && !q.role && ev.addr_ack_slot && en && !q.flags[B_ARB]
    |=> !q.flags[B_ARB])
    else $error("arbitration lost at SMBus address ACK");
  misplaced_cond_a: assert property ( // [R4]
    (start_c || stop_c) && illegal && en |=> q.flags[B_MISP])
    else $error("misplaced condition not flagged");
  write_through_a: assert property ( // [R8]
    do_wr && hit(q.waddr, DATA_OFS) && q.wstrb[0] && (q.first || q.flags[B_BYTE])
    |=> q.txload && q.txout == $past(q.wdata[7:0]))
    else $error("write under byte-done not passed to shifter");
  rx_land_a: assert property ( // [R9]
    rx_take && en && !q.flags[B_RXF] && !do_rd |=> q.flags[B_RXF] ##0 q.rxbuf == $past(ev.rx_byte))
    else $error("received byte not stored");
  stop_flag_a: assert property ( // [R11]
    stop_c && en && !q.role && q.lastack && q.busy |=> q.flags[B_STOP])
    else $error("target stop not flagged");
  addr_clear_a: assert property ( // [R19]
    do_rd && hit(s_axi_araddr, STATUS_TWO_REGISTER_OFS) && q.armed && !ev.addr_done && !ev.addr_match
    |=> !q.flags[B_ADDR])
    else $error("address flag not cleared");
  start_sent_a: assert property ( // [R20]
    ev.start_sent && !ev.arb_lost && en |=> q.flags[B_START] && q.role)
    else $error("start not flagged");
  resp_hold_a: assert property (
    q.bvalid && !s_axi_bready |=> q.bvalid && $stable(q.bresp))
    else $error("write answer dropped");

  start_seen_c: cover property (ev.start_sent ##[1:50] q.flags[B_ADDR]);
  byte_done_c: cover property ($rose(q.flags[B_BYTE]));
  stop_seen_c: cover property ($rose(q.flags[B_STOP]));
  overrun_c: cover property ($rose(q.flags[B_OVR]));

endmodule : i2c_status_flags
`default_nettype wire

// [i2c_bus_party.sv]
// Behavioural I2C bus party that drives SCL and SDA of the flag block.
// Assumes pull-ups: a released line reads high; SCL runs only inside frames.
`default_nettype none
module i2c_bus_party (
  output logic scl,  // Clock line, high when released
  output logic sda   // Data line, high when released
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 100;  // Half of the 200 ns link period
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start: data falls while clock high; only called from idle
  task automatic start_c();
    #(HALF);
    sda = 1'b0;
    #(HALF);
  endtask : start_c
  // Bit slots; data moves only while clock low
  task automatic bits(input int n);
    for (int i = 0; i < n; i++) begin
      scl = 1'b0;
      #(HALF / 2);
      sda = 1'($urandom_range(0, 1));
      #(HALF / 2);
      scl = 1'b1;
      #(HALF);
    end
  endtask : bits
  // Stop: data rises while clock high, then clock stands still
  task automatic stop_c();
    scl = 1'b0;
    #(HALF / 2);
    sda = 1'b0;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF);
    sda = 1'b1;
    #(HALF);
  endtask : stop_c
endmodule : i2c_bus_party
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the status-flag block against a flag model.
// Assumes the byte engine is played here and a bus party drives the pins.
`default_nettype none
`define CHK(nm, ex, sn) \
  begin \
    n_tests++; \
    if ((sn) !== (ex)) begin \
      $display("wrong value %s expected %h seen %h", nm, ex, sn); \
      miscompares++; \
    end \
  end
module testbench import i2c_flag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;             // Clock and reset
  logic [4:0]  awaddr, araddr;            // Bus addresses
  logic        awvalid, wvalid, bready;   // Write handshakes
  logic        arvalid, rready;           // Read handshakes
  logic [31:0] wdata, rdata;              // Bus data
  logic [3:0]  wstrb;                     // Write strobes
  logic        awready, wready, bvalid;   // Slave write answers
  logic        arready, rvalid;           // Slave read answers
  logic [1:0]  bresp, rresp;              // Answer codes
  wire logic   scl, sda;                  // Bus pins from the party
  core_ev_s    ev;                        // Byte engine events
  logic [7:0]  tx_byte;                   // Byte to shifter
  logic        tx_load, en_o, nostr_o;    // Shifter and control outputs
  logic        pec_o, role_o;             // Control and role outputs
  int          miscompares = 0;           // Mismatch count
  int          n_tests = 0;               // Comparison count
  logic [15:0] exp_status_one_register;                  // Model of status one
  logic [7:0]  rx_q[$];                   // Model of received bytes
  logic [31:0] rd;                        // Last read data
  logic [1:0]  rsp;                       // Last answer code

  i2c_status_flags uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl), .sda_in(sda),
    .ev(ev), .tx_byte(tx_byte), .tx_load(tx_load), .periph_enable(en_o),
    .stretch_disable(nostr_o), .pec_request(pec_o), .controller_role_flag(role_o)
  );
  i2c_bus_party party (.scl(scl), .sda(sda));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Watchdog, well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end

  // Write: both halves offered together, each released when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // No fixed latency assumed; the watchdog bounds the wait
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // Read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Status one against the model; this read also arms the clears
  task automatic chk1();
    axi_rd(STATUS_ONE_REGISTER_OFS);
    `CHK("status one", {16'h0000, exp_status_one_register}, rd)
  endtask : chk1

  // One-cycle event from the byte engine
  task automatic pulse(input core_ev_s e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
  endtask : pulse

  // Received byte into engine and model
  task automatic rx_one();
    logic [7:0] b;
    b = 8'($urandom);
    rx_q.push_back(b);
    pulse('{byte_rx: 1'b1, rx_byte: b, default: '0});
  endtask : rx_one

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    ev = '0;
    exp_status_one_register = 16'h0000;
    void'($urandom(2));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk1();
    // Unmapped places answer with an error; ones to status one do nothing
    axi_rd(5'h04);
    `CHK("read answer", RESP_SLVERR, rsp)
    axi_wr(5'h08, $urandom, 4'hF);
    `CHK("write answer", RESP_SLVERR, rsp)
    axi_wr(STATUS_ONE_REGISTER_OFS, 32'h0000FFFF, 4'hF);
    chk1();
    axi_wr(CTRL_OFS, 32'h5, 4'h1);
    `CHK("control", 3'h5, {pec_o, nostr_o, en_o})
    // Transmit-empty gated by address phase and PEC next
    pulse('{byte_req: 1'b1, tx_dir: 1'b1, addr_stage: 1'b1, default: '0});
    chk1();
    pulse('{byte_req: 1'b1, tx_dir: 1'b1, pec_next: 1'b1, default: '0});
    chk1();
    pulse('{byte_req: 1'b1, tx_dir: 1'b1, default: '0});
    exp_status_one_register[B_TXE] = 1'b1;
    chk1();
    pulse('{byte_req: 1'b1, tx_dir: 1'b1, default: '0});
    exp_status_one_register[B_BYTE] = 1'b1;
    chk1();
    // Start in transmit direction clears empty and byte-done
    pulse('{start_sent: 1'b1, tx_dir: 1'b1, default: '0});
    exp_status_one_register = 16'h0001;
    chk1();
    `CHK("role", 1'b1, role_o)
    axi_wr(DATA_OFS, {24'h0, 8'($urandom)}, 4'h1);
    exp_status_one_register[B_START] = 1'b0;
    chk1();
    // Address flag: set, cleared by status two read, refused on NACK
    pulse('{addr_done: 1'b1, default: '0});
    exp_status_one_register[B_ADDR] = 1'b1;
    chk1();
    axi_rd(STATUS_TWO_REGISTER_OFS);
    `CHK("status two", 32'h1, rd)
    exp_status_one_register[B_ADDR] = 1'b0;
    chk1();
    pulse('{addr_done: 1'b1, nack: 1'b1, default: '0});
    chk1();
    // Arbitration loss drops to target role; then target-only checks
    pulse('{arb_lost: 1'b1, default: '0});
    exp_status_one_register[B_ARB] = 1'b1;
    chk1();
    `CHK("role", 1'b0, role_o)
    axi_wr(STATUS_ONE_REGISTER_OFS, 32'h0, 4'h2);
    exp_status_one_register[B_ARB] = 1'b0;
    chk1();
    pulse('{arb_lost: 1'b1, smbus: 1'b1, addr_ack_slot: 1'b1, default: '0});
    chk1();
    pulse('{addr_match: 1'b1, default: '0});
    exp_status_one_register[B_ADDR] = 1'b1;
    axi_rd(DATA_OFS);
    axi_rd(STATUS_TWO_REGISTER_OFS);
    chk1();
    // Header flag, refused on NACK, cleared by read then control write
    pulse('{hdr_sent: 1'b1, nack: 1'b1, default: '0});
    chk1();
    pulse('{hdr_sent: 1'b1, default: '0});
    exp_status_one_register[B_HDR] = 1'b1;
    chk1();
    axi_wr(CTRL_OFS, 32'h1, 4'h1);
    exp_status_one_register[B_HDR] = 1'b0;
    chk1();
    // Stop three bits into a slot is misplaced and ends controller role
    pulse('{start_sent: 1'b1, default: '0});
    exp_status_one_register[B_START] = 1'b1;
    party.start_c();
    party.bits(3);
    party.stop_c();
    repeat (8) @(posedge aclk);
    exp_status_one_register[B_MISP] = 1'b1;
    chk1();
    `CHK("role", 1'b0, role_o)
    axi_wr(STATUS_ONE_REGISTER_OFS, 32'h0, 4'h2);
    exp_status_one_register[B_MISP] = 1'b0;
    // Second byte while full sets byte-done; reads drain in order
    rx_one();
    rx_one();
    exp_status_one_register[B_RXF] = 1'b1;
    exp_status_one_register[B_BYTE] = 1'b1;
    chk1();
    axi_rd(DATA_OFS);
    `CHK("rx data", {24'h0, rx_q.pop_front()}, rd)
    exp_status_one_register[B_BYTE] = 1'b0;
    chk1();
    axi_rd(DATA_OFS);
    `CHK("rx data", {24'h0, rx_q.pop_front()}, rd)
    exp_status_one_register[B_RXF] = 1'b0;
    chk1();
    // Target stop after an acked byte, over a well-formed slot
    party.start_c();
    rx_one();
    party.bits(9);
    party.stop_c();
    repeat (8) @(posedge aclk);
    exp_status_one_register[B_RXF] = 1'b1;
    exp_status_one_register[B_STOP] = 1'b1;
    chk1();
    axi_rd(DATA_OFS);
    `CHK("rx data", {24'h0, rx_q.pop_front()}, rd)
    exp_status_one_register[B_RXF] = 1'b0;
    axi_wr(CTRL_OFS, 32'h1, 4'h1);
    chk1();
    axi_wr(CTRL_OFS, 32'h1, 4'h1);
    exp_status_one_register[B_STOP] = 1'b0;
    chk1();
    // Disable clears every flag
    axi_wr(CTRL_OFS, 32'h0, 4'h1);
    exp_status_one_register = 16'h0000;
    chk1();
    `CHK("enable", 1'b0, en_o)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
